// ### hdl/ppp_pkg.sv
// Constants, pin carriers and state types of the parallel programming port
package ppp_pkg;

   // Command byte coding
   localparam logic [7:0] CMD_NOP      = 8'h00;
   localparam logic [7:0] CMD_ERASE    = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EE    = 8'h11;
   localparam logic [7:0] CMD_RD_SIG   = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EE    = 8'h03;

   // Action select coding {action_sel_high, action_sel_low}
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;

   // Memory geometry
   localparam int FLASH_AW    = 13;
   localparam int FLASH_WORDS = 8192;
   localparam int PG_WORD_W   = 6;
   localparam int PG_WORDS    = 64;
   localparam int EE_AW       = 9;
   localparam int EE_BYTES    = 512;
   localparam int EE_PG_W     = 2;
   localparam int EE_PG_BYTES = 4;
   localparam logic [FLASH_AW-1:0] ERASE_LAST = 13'h1FFF;

   // Fuse, lock and signature layout
   localparam logic [7:0] FUSE_LO_RST  = 8'h62;
   localparam logic [7:0] FUSE_HI_RST  = 8'hFF;
   localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
   localparam logic [7:0] LOCK_RST     = 8'hFF;
   localparam int         KEEP_EE_BIT  = 3;
   localparam int         LOCK_A_BIT   = 0;
   localparam int         LOCK_B_BIT   = 1;
   localparam logic [7:0] BOOT_LOCK_M  = 8'h3C;
   localparam logic [7:0] ERASED_BYTE  = 8'hFF;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [7:0] SIG_LAST     = 8'h02;
   localparam logic [7:0] CAL_ADDR     = 8'h00;

   // Entry sequence
   localparam logic [2:0] ENTRY_TOGGLES = 3'h6;

   // Timing at 100 MHz
   localparam int CLK_PERIOD_NS   = 10;
   localparam int ENTRY_QUIET_NS  = 100;
   localparam int ENTRY_QUIET_CYC = (ENTRY_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_TIME_NS   = 3700000;
   localparam int WRITE_CYC       = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_TIME_NS   = 7500000;
   localparam int ERASE_CYC       = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_CNT_W      = 20;

   // Control pins as one carrier
   typedef struct packed {
      logic load_strobe;
      logic action_sel_high;
      logic action_sel_low;
      logic byte_pick_one;
      logic byte_pick_two;
      logic buffer_latch_strobe;
      logic program_strike_n;
      logic output_enable_n;
   } ppp_pins_s;

   typedef enum logic [2:0] {
      MODE_OUT, MODE_ARMED, MODE_CHECK, MODE_PROG, MODE_FAIL
   } ppp_mode_e;

   typedef struct packed {
      ppp_mode_e  mode;
      logic [2:0] toggles;
      logic [3:0] quiet;
      ppp_pins_s  pins_d;
      logic [7:0] cmd;
      logic [7:0] addr_lo;
      logic [7:0] addr_hi;
      logic [7:0] data_lo;
      logic [7:0] data_hi;
      logic [7:0] fuse_lo;
      logic [7:0] fuse_hi;
      logic [7:0] fuse_ext;
      logic [7:0] lock;
      logic       erase_run;
      logic [FLASH_AW-1:0] erase_idx;
      logic [7:0] dout;
      logic       doe;
      logic       done;
      logic       prog;
   } ppp_state_s;

endpackage

// ### hdl/ppp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ppp_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } ppp_sync_s;

   ppp_sync_s sync_ff;
   ppp_sync_s nxt_sync;

   always_comb begin
      nxt_sync    = sync_ff;
      nxt_sync.s1 = d;
      nxt_sync.s2 = sync_ff.s1;
      nxt_sync.s3 = sync_ff.s2;
      // Follow only bits where stages two and three agree
      nxt_sync.q  = (~(sync_ff.s2 ^ sync_ff.s3) & sync_ff.s3)
                  | ((sync_ff.s2 ^ sync_ff.s3) & sync_ff.q);
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sync_ff <= '0;
      end else if (clk_en) begin
         sync_ff <= nxt_sync;
      end
   end

   assign q = sync_ff.q;
endmodule // ppp_sync
`default_nettype wire

// ### hdl/ppp_busy.sv
// Self-timed programming delay counter
`timescale 1ns/100ps
`default_nettype none
module ppp_busy
   import ppp_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   input  wire logic                  clk_en,
   input  wire logic                  start,
   input  wire logic [BUSY_CNT_W-1:0] cycles,
   output logic                       busy
);
   typedef struct packed {
      logic [BUSY_CNT_W-1:0] cnt;
   } ppp_busy_s;

   ppp_busy_s busy_ff;
   ppp_busy_s nxt_busy;

   always_comb begin
      nxt_busy = busy_ff;
      if (start) begin
         nxt_busy.cnt = cycles;
      end else if (busy_ff.cnt != '0) begin
         nxt_busy.cnt = busy_ff.cnt - BUSY_CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         busy_ff <= '0;
      end else if (clk_en) begin
         busy_ff <= nxt_busy;
      end
   end

   assign busy = (busy_ff.cnt != '0);
endmodule // ppp_busy
`default_nettype wire

// ### hdl/ppp_port.sv
// Parallel programming port: entry, command decode, page buffers, memories
//
// What this block does
// R01 - Decode erase, fuse, lock, Flash, EEPROM write commands
// R02 - Decode signature, fuse/lock, Flash, EEPROM read commands
// R03 - Programmer toggles strobe six times, zeros pattern
// R04 - Pattern change soon after high voltage refuses entry
// R05 - Programmer waits 50 us before first command
// R06 - Command and address held across many accesses
// R07 - Address high byte kept until reloaded
// R08 - Action select picks command, address or data load
// R09 - Write strike starts operation, done flag low
// R10 - Erase Flash, EEPROM, then locks; fuses kept
// R11 - Keep-EEPROM fuse protects EEPROM from erase
// R12 - Latch strobe stores data word in page buffer
// R13 - Programmer loads words, latches, then strikes write
// R14 - Low address bits pick word, upper pick page
// R15 - No-operation command clears pending page writes
// R16 - EEPROM write command strike programs buffered page
// R17 - Flash read gives low or high byte
// R18 - EEPROM read gives addressed byte
// R19 - Fuse write sets byte chosen by byte picks
// R20 - Lock write programs zeros; level three guards boot
// R21 - Fuse/lock read selects byte by byte picks
// R22 - Signature read by address; calibration at zero
// R23 - Done flag low while busy, high when ready
// R24 - Data bus driven only while output enable low
// R25 - Action select 11 load does nothing
`timescale 1ns/100ps
`default_nettype none
module ppp_port
   import ppp_pkg::*;
#(
   parameter int         WRITE_CYCLES = WRITE_CYC,
   parameter int         ERASE_CYCLES = ERASE_CYC,
   parameter logic [7:0] SIG_BYTE0    = 8'hA5,   // Arbitrary identity value
   parameter logic [7:0] SIG_BYTE1    = 8'h5A,   // Arbitrary identity value
   parameter logic [7:0] SIG_BYTE2    = 8'h3C,   // Arbitrary identity value
   parameter logic [7:0] CAL_BYTE     = 8'h80
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       clk_en,
   input  wire ppp_pins_s  pins,
   input  wire logic [7:0] data_in,
   input  wire logic       reset_pin_low,
   input  wire logic       reset_pin_hv,
   output logic      [7:0] data_out,
   output logic            data_oe,
   output logic            done_flag,
   output logic            prog_mode
);
   ppp_state_s st_ff;
   ppp_state_s nxt_st;

   // Synchronised view of every pin
   ppp_pins_s  pin_s;
   logic [7:0] din_s;
   logic       rlow_s;
   logic       hv_s;

   ppp_sync #(.W(18)) u_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clk_en  (clk_en),
      .d       ({pins, data_in, reset_pin_low, reset_pin_hv}),
      .q       ({pin_s, din_s, rlow_s, hv_s})
   );

   // Nonvolatile arrays and page buffers
   logic [15:0] flash_mem [FLASH_WORDS];
   logic [7:0]  ee_mem    [EE_BYTES];
   logic [15:0] flash_buf [PG_WORDS];
   logic [7:0]  ee_buf    [EE_PG_BYTES];

   logic                  timer_start;
   logic [BUSY_CNT_W-1:0] timer_cycles;
   logic                  timer_busy;

   ppp_busy u_busy (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clk_en  (clk_en),
      .start   (timer_start),
      .cycles  (timer_cycles),
      .busy    (timer_busy)
   );

   // Decoded events
   logic        strobe_rise;
   logic        latch_rise;
   logic        strike_fall;
   logic [1:0]  act;
   logic [3:0]  entry_pat;
   logic        busy;
   logic        flash_pg_wr;
   logic        ee_pg_wr;
   logic        buf_latch;
   logic        buf_clear;
   logic        erase_step;
   logic        keep_ee;
   logic [FLASH_AW-1:0] flash_addr;
   logic [EE_AW-1:0]    ee_addr;
   logic [15:0] flash_rd;
   logic [7:0]  ee_rd;
   logic [7:0]  rd_byte;

   assign act        = {pin_s.action_sel_high, pin_s.action_sel_low};
   assign entry_pat  = {pin_s.buffer_latch_strobe, pin_s.action_sel_high,
                        pin_s.action_sel_low, pin_s.byte_pick_one};
   assign strobe_rise = pin_s.load_strobe & ~st_ff.pins_d.load_strobe;
   assign latch_rise  = pin_s.buffer_latch_strobe & ~st_ff.pins_d.buffer_latch_strobe;
   assign strike_fall = ~pin_s.program_strike_n & st_ff.pins_d.program_strike_n;
   assign busy        = timer_busy | st_ff.erase_run;
   assign keep_ee     = ~st_ff.fuse_hi[KEEP_EE_BIT];   // see R11
   // High byte kept in its own field, so windows need only one reload
   assign flash_addr  = {st_ff.addr_hi[FLASH_AW-9:0], st_ff.addr_lo};   // see R07
   assign ee_addr     = {st_ff.addr_hi[EE_AW-9:0], st_ff.addr_lo};
   assign flash_rd    = flash_mem[flash_addr];
   assign ee_rd       = ee_mem[ee_addr];

   // Read data selection
   always_comb begin
      rd_byte = ERASED_BYTE;
      case (st_ff.cmd)
         CMD_RD_FLASH: begin
            rd_byte = pin_s.byte_pick_one ? flash_rd[15:8] : flash_rd[7:0];   // see R17
         end
         CMD_RD_EE: begin
            rd_byte = ee_rd;   // see R18
         end
         CMD_RD_FUSE: begin
            case ({pin_s.byte_pick_two, pin_s.byte_pick_one})   // see R21
               2'h0:    rd_byte = st_ff.fuse_lo;
               2'h3:    rd_byte = st_ff.fuse_hi;
               2'h2:    rd_byte = st_ff.fuse_ext;
               default: rd_byte = st_ff.lock;
            endcase
         end
         CMD_RD_SIG: begin
            if (pin_s.byte_pick_one) begin
               rd_byte = (st_ff.addr_lo == CAL_ADDR) ? CAL_BYTE : ERASED_BYTE;   // see R22
            end else begin
               case (st_ff.addr_lo)   // see R22
                  8'h00:   rd_byte = SIG_BYTE0;
                  8'h01:   rd_byte = SIG_BYTE1;
                  SIG_LAST: rd_byte = SIG_BYTE2;
                  default: rd_byte = ERASED_BYTE;
               endcase
            end
         end
         default: rd_byte = ERASED_BYTE;
      endcase
   end

   // Control state
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.pins_d = pin_s;
      timer_start  = 1'b0;
      timer_cycles = '0;
      flash_pg_wr  = 1'b0;
      ee_pg_wr     = 1'b0;
      buf_latch    = 1'b0;
      buf_clear    = 1'b0;
      erase_step   = 1'b0;

      case (st_ff.mode)
         MODE_OUT: begin
            nxt_st.toggles = '0;
            if (rlow_s && !hv_s) begin
               nxt_st.mode = MODE_ARMED;
            end
         end
         MODE_ARMED: begin
            if (strobe_rise && st_ff.toggles != ENTRY_TOGGLES) begin
               nxt_st.toggles = st_ff.toggles + 3'h1;
            end
            if (hv_s) begin
               // Six toggles and a zero pattern are needed before the voltage
               if (st_ff.toggles == ENTRY_TOGGLES && entry_pat == 4'h0) begin
                  nxt_st.mode  = MODE_CHECK;
                  nxt_st.quiet = 4'(ENTRY_QUIET_CYC);
               end else begin
                  nxt_st.mode = MODE_FAIL;
               end
            end else if (!rlow_s) begin
               nxt_st.mode = MODE_OUT;
            end
         end
         MODE_CHECK: begin
            if (!hv_s) begin
               nxt_st.mode = MODE_OUT;
            end else if (entry_pat != 4'h0) begin
               nxt_st.mode = MODE_FAIL;   // see R04
            end else if (st_ff.quiet == 4'h1) begin
               nxt_st.mode = MODE_PROG;
               nxt_st.prog = 1'b1;
               nxt_st.cmd  = CMD_NOP;
            end else begin
               nxt_st.quiet = st_ff.quiet - 4'h1;
            end
         end
         MODE_FAIL: begin
            // Stays refused until the high voltage is removed
            if (!hv_s) begin
               nxt_st.mode = MODE_OUT;
            end
         end
         MODE_PROG: begin
            if (!hv_s) begin
               nxt_st.mode = MODE_OUT;
               nxt_st.prog = 1'b0;
            end else if (strobe_rise && !busy) begin
               // Loaded fields persist until overwritten
               case (act)   // see R06
                  ACT_CMD: begin
                     nxt_st.cmd = din_s;   // see R08
                     if (din_s == CMD_NOP) begin
                        buf_clear = 1'b1;   // see R15
                     end
                  end
                  ACT_ADDR: begin
                     if (pin_s.byte_pick_one) begin
                        nxt_st.addr_hi = din_s;   // see R07
                     end else begin
                        nxt_st.addr_lo = din_s;
                     end
                  end
                  ACT_DATA: begin
                     if (pin_s.byte_pick_one) begin
                        nxt_st.data_hi = din_s;
                     end else begin
                        nxt_st.data_lo = din_s;
                     end
                  end
                  ACT_IDLE: begin
                     nxt_st.cmd = st_ff.cmd;   // see R25
                  end
                  default: nxt_st.cmd = st_ff.cmd;
               endcase
            end else if (latch_rise && !busy) begin
               buf_latch = (st_ff.cmd == CMD_WR_EE) || pin_s.byte_pick_one;   // see R12
            end else if (strike_fall && !busy) begin
               case (st_ff.cmd)   // see R01
                  CMD_ERASE: begin
                     nxt_st.erase_run = 1'b1;   // see R10
                     nxt_st.erase_idx = '0;
                     timer_start      = 1'b1;   // see R09
                     timer_cycles     = BUSY_CNT_W'(ERASE_CYCLES);
                  end
                  CMD_WR_FLASH: begin
                     flash_pg_wr  = 1'b1;   // see R14
                     timer_start  = 1'b1;
                     timer_cycles = BUSY_CNT_W'(WRITE_CYCLES);
                  end
                  CMD_WR_EE: begin
                     ee_pg_wr     = ~pin_s.byte_pick_one;   // see R16
                     timer_start  = ~pin_s.byte_pick_one;
                     timer_cycles = BUSY_CNT_W'(WRITE_CYCLES);
                  end
                  CMD_WR_FUSE: begin
                     // Fuses freeze once the first lock bit is programmed
                     if (st_ff.lock[LOCK_A_BIT]) begin
                        case ({pin_s.byte_pick_two, pin_s.byte_pick_one})   // see R19
                           2'h0:    nxt_st.fuse_lo  = st_ff.data_lo;
                           2'h1:    nxt_st.fuse_hi  = st_ff.data_lo;
                           2'h2:    nxt_st.fuse_ext = st_ff.data_lo;
                           default: nxt_st.fuse_lo  = st_ff.fuse_lo;
                        endcase
                     end
                     timer_start  = 1'b1;
                     timer_cycles = BUSY_CNT_W'(WRITE_CYCLES);
                  end
                  CMD_WR_LOCK: begin
                     // Only zeros are written; ones never clear a lock bit
                     if (!st_ff.lock[LOCK_A_BIT] && !st_ff.lock[LOCK_B_BIT]) begin
                        nxt_st.lock = st_ff.lock & (st_ff.data_lo | BOOT_LOCK_M);   // see R20
                     end else begin
                        nxt_st.lock = st_ff.lock & st_ff.data_lo;   // see R20
                     end
                     timer_start  = 1'b1;
                     timer_cycles = BUSY_CNT_W'(WRITE_CYCLES);
                  end
                  default: nxt_st.cmd = st_ff.cmd;
               endcase
            end
         end
         default: nxt_st.mode = MODE_OUT;
      endcase

      if (st_ff.erase_run) begin
         erase_step       = 1'b1;
         nxt_st.erase_idx = st_ff.erase_idx + FLASH_AW'(1);
         if (st_ff.erase_idx == ERASE_LAST) begin
            nxt_st.erase_run = 1'b0;
            nxt_st.lock      = LOCK_RST;   // see R10
         end
      end

      nxt_st.done = ~(busy | timer_start);   // see R23
      nxt_st.doe  = st_ff.prog & ~pin_s.output_enable_n;   // see R24
      nxt_st.dout = rd_byte;   // see R02
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_ff          <= '0;
         st_ff.mode     <= MODE_OUT;
         st_ff.pins_d   <= '1;
         st_ff.fuse_lo  <= FUSE_LO_RST;
         st_ff.fuse_hi  <= FUSE_HI_RST;
         st_ff.fuse_ext <= FUSE_EXT_RST;
         st_ff.lock     <= LOCK_RST;
         st_ff.done     <= 1'b1;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // Arrays: program only clears bits, so unlatched buffer words change nothing
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (buf_clear || flash_pg_wr || ee_pg_wr || !rstn) begin
            for (int i = 0; i < PG_WORDS; i++) begin
               flash_buf[i] <= ERASED_WORD;
            end
            for (int i = 0; i < EE_PG_BYTES; i++) begin
               ee_buf[i] <= ERASED_BYTE;
            end
         end else if (buf_latch) begin
            flash_buf[st_ff.addr_lo[PG_WORD_W-1:0]] <= {st_ff.data_hi, st_ff.data_lo};
            ee_buf[st_ff.addr_lo[EE_PG_W-1:0]]      <= st_ff.data_lo;   // see R12
         end
         if (flash_pg_wr) begin
            for (int i = 0; i < PG_WORDS; i++) begin
               flash_mem[{flash_addr[FLASH_AW-1:PG_WORD_W], PG_WORD_W'(i)}] <=
                  flash_mem[{flash_addr[FLASH_AW-1:PG_WORD_W], PG_WORD_W'(i)}] & flash_buf[i];
            end
         end
         if (ee_pg_wr) begin
            for (int i = 0; i < EE_PG_BYTES; i++) begin
               ee_mem[{ee_addr[EE_AW-1:EE_PG_W], EE_PG_W'(i)}] <=
                  ee_mem[{ee_addr[EE_AW-1:EE_PG_W], EE_PG_W'(i)}] & ee_buf[i];
            end
         end
         if (erase_step) begin
            flash_mem[st_ff.erase_idx] <= ERASED_WORD;   // see R10
            if (!keep_ee && st_ff.erase_idx < FLASH_AW'(EE_BYTES)) begin
               ee_mem[st_ff.erase_idx[EE_AW-1:0]] <= ERASED_BYTE;   // see R11
            end
         end
      end
   end

   assign data_out  = st_ff.dout;
   assign data_oe   = st_ff.doe;
   assign done_flag = st_ff.done;
   assign prog_mode = st_ff.prog;
endmodule // ppp_port
`default_nettype wire

// ### test/ppp_port_sva.sv
// Concurrent checks on the programming port pins
`timescale 1ns/100ps
`default_nettype none
module ppp_port_sva
   import ppp_pkg::*;
#(
   parameter int ERASE_CYCLES = ERASE_CYC
) (
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire ppp_pins_s  pins,
   input wire logic       reset_pin_hv,
   input wire logic [7:0] data_out,
   input wire logic       data_oe,
   input wire logic       done_flag,
   input wire logic       prog_mode
);
   logic [19:0] busy_ff;
   always_ff @(posedge sys_clk) begin
      busy_ff <= (!rstn || done_flag) ? 20'h00000 : busy_ff + 20'h00001;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_reset_values:
      assert property ($rose(rstn) |-> done_flag && !data_oe && !prog_mode && data_out == 8'h00)
      else $error("outputs not at reset values");
   a_oe_needs_mode:
      assert property (data_oe |-> prog_mode) else $error("bus driven outside mode");
   a_oe_follows:
      assert property ((!pins.output_enable_n && prog_mode)[*8] |-> data_oe)
      else $error("bus not driven");
   a_oe_released:
      assert property (pins.output_enable_n[*8] |-> !data_oe) else $error("bus not released");
   a_mode_needs_hv:
      assert property (!reset_pin_hv[*8] |-> !prog_mode) else $error("mode without voltage");
   a_entry_quiet:
      assert property ($rose(prog_mode) |-> $past(reset_pin_hv, 10))
      else $error("entry too early");
   a_strike_cause:
      assert property ($fell(done_flag) |-> !$past(pins.program_strike_n, 3) && prog_mode)
      else $error("busy without strike");
   a_busy_min:
      assert property ($fell(done_flag) |=> !done_flag[*8]) else $error("busy too short");
   a_busy_max:
      assert property (busy_ff < 20'(ERASE_CYCLES + 64)) else $error("busy too long");
   c_entry: cover property ($rose(prog_mode));
   c_busy: cover property ($fell(done_flag));
   c_read: cover property ($rose(data_oe));
endmodule // ppp_port_sva
bind ppp_port ppp_port_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (
   .sys_clk(sys_clk), .rstn(rstn), .pins(pins), .reset_pin_hv(reset_pin_hv),
   .data_out(data_out), .data_oe(data_oe), .done_flag(done_flag), .prog_mode(prog_mode));
`default_nettype wire

// ### test/ppp_prog_model.sv
// Behavioural external programmer driving the port pins
`timescale 1ns/100ps
`default_nettype none
module ppp_prog_model
   import ppp_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   input  wire logic       done_flag,
   output var  ppp_pins_s  pins,
   output var  logic [7:0] data_in,
   output var  logic       reset_pin_low,
   output var  logic       reset_pin_hv,
   output wire logic [7:0] bus
);
   assign bus = data_oe ? data_out : data_in;
   initial begin
      pins = ppp_pins_s'(8'h03);
      data_in = 8'h00;
      reset_pin_low = 1'b0;
      reset_pin_hv = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Pulses of 12 cycles clear the 4-cycle pin filter; b is the strobe's bit in pins
   task automatic pulse(input int b);
      wt(12);
      pins[b] = 1'b1;
      wt(12);
      pins[b] = 1'b0;
      wt(12);
   endtask
   task automatic enter(input logic bad);
      reset_pin_low = 1'b1;
      repeat (6) pulse(7);
      pins = ppp_pins_s'(8'h03);
      pins.byte_pick_one = bad;
      wt(12);
      reset_pin_low = 1'b0;
      reset_pin_hv = 1'b1;
      wt(5100);
   endtask
   task automatic leave();
      reset_pin_hv = 1'b0;
      reset_pin_low = 1'b1;
      wt(20);
   endtask
   task automatic ld(input logic [1:0] act, input logic bs1, input logic [7:0] v);
      {pins.action_sel_high, pins.action_sel_low} = act;
      {pins.byte_pick_one, pins.byte_pick_two} = {bs1, 1'b0};
      data_in = v;
      pulse(7);
   endtask
   task automatic latch();
      pins.byte_pick_one = 1'b1;
      pulse(2);
   endtask
   task automatic strike(input logic bs1, bs2, output logic ok);
      {pins.byte_pick_one, pins.byte_pick_two} = {bs1, bs2};
      wt(12);
      pins.program_strike_n = 1'b0;
      wt(12);
      ok = (done_flag === 1'b0);
      pins.program_strike_n = 1'b1;
      for (int i = 0; i < 12000 && done_flag !== 1'b1; i++) wt(1);
      ok = ok && (done_flag === 1'b1);
   endtask
   // Released bus shows inverted data so a stale value cannot pass
   task automatic rd(input logic bs1, bs2, output logic [7:0] v);
      {pins.byte_pick_one, pins.byte_pick_two} = {bs1, bs2};
      data_in = ~data_in;
      pins.output_enable_n = 1'b0;
      wt(12);
      v = bus;
      pins.output_enable_n = 1'b1;
      wt(12);
   endtask
endmodule // ppp_prog_model
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the parallel programming port
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ppp_pkg::*;
   logic       sys_clk, rstn, clk_en, reset_pin_low, reset_pin_hv, data_oe, done_flag, prog_mode;
   ppp_pins_s  pins;
   logic [7:0] data_in, data_out;
   wire  [7:0] bus;
   int         n_mismatch = 0;
   int         n_tests = 0;
   ppp_port #(.WRITE_CYCLES(50), .ERASE_CYCLES(9000)) dut (.sys_clk(sys_clk), .rstn(rstn),
      .clk_en(clk_en), .pins(pins), .data_in(data_in), .reset_pin_low(reset_pin_low),
      .reset_pin_hv(reset_pin_hv), .data_out(data_out), .data_oe(data_oe),
      .done_flag(done_flag), .prog_mode(prog_mode));
   ppp_prog_model prog (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
      .done_flag(done_flag), .pins(pins), .data_in(data_in), .reset_pin_low(reset_pin_low),
      .reset_pin_hv(reset_pin_hv), .bus(bus));
   task automatic chk(input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic bs1, bs2);
      logic ok;
      prog.strike(bs1, bs2, ok);
      chk(8'(ok), 8'h01);
      if (!ok) finish_test();
   endtask
   task automatic rc(input logic bs1, bs2, input logic [7:0] e);
      logic [7:0] v;
      prog.rd(bs1, bs2, v);
      chk(v, e);
   endtask
   task automatic rdm(input logic [7:0] cmd, lo, e, input logic bs1);
      prog.ld(ACT_CMD, 1'b0, cmd);
      prog.ld(ACT_ADDR, 1'b0, lo);
      rc(bs1, 1'b0, e);
   endtask
   task automatic t_entry();
      prog.enter(1'b1);
      chk(8'(prog_mode), 8'h00);
      prog.leave();
      prog.enter(1'b0);
      chk(8'(prog_mode), 8'h01);
   endtask
   task automatic t_sig();
      logic [7:0] sig [3] = '{8'hA5, 8'h5A, 8'h3C};
      for (int i = 0; i < 3; i++) begin
         rdm(CMD_RD_SIG, 8'(i), sig[i], 1'b0);
      end
      prog.ld(ACT_IDLE, 1'b0, 8'h00);
      rc(1'b0, 1'b0, sig[2]);
      rdm(CMD_RD_SIG, CAL_ADDR, 8'h80, 1'b1);
   endtask
   task automatic t_fuse();
      prog.ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
      rc(1'b0, 1'b0, FUSE_LO_RST);
      rc(1'b1, 1'b1, FUSE_HI_RST);
      rc(1'b0, 1'b1, FUSE_EXT_RST);
      rc(1'b1, 1'b0, LOCK_RST);
      prog.ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
      prog.ld(ACT_DATA, 1'b0, 8'h55);
      wr(1'b0, 1'b0);
      prog.ld(ACT_DATA, 1'b0, 8'hF0);
      wr(1'b0, 1'b1);
      prog.ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
      rc(1'b0, 1'b0, 8'h55);
      rc(1'b0, 1'b1, 8'hF0);
   endtask
   task automatic t_erase();
      prog.ld(ACT_CMD, 1'b0, CMD_ERASE);
      wr(1'b0, 1'b0);
      prog.ld(ACT_ADDR, 1'b1, 8'h00);
      rdm(CMD_RD_EE, 8'h05, ERASED_BYTE, 1'b0);
      rdm(CMD_RD_FLASH, 8'h41, ERASED_BYTE, 1'b1);
   endtask
   task automatic t_ee();
      prog.ld(ACT_CMD, 1'b0, CMD_WR_EE);
      prog.ld(ACT_ADDR, 1'b0, 8'h05);
      prog.ld(ACT_DATA, 1'b0, 8'hA7);
      prog.latch();
      wr(1'b0, 1'b0);
      rdm(CMD_RD_EE, 8'h05, 8'hA7, 1'b0);
   endtask
   task automatic t_flash();
      prog.ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
      prog.ld(ACT_ADDR, 1'b0, 8'h41);
      prog.ld(ACT_DATA, 1'b0, 8'h34);
      prog.ld(ACT_DATA, 1'b1, 8'h12);
      prog.latch();
      prog.ld(ACT_ADDR, 1'b1, 8'h01);
      wr(1'b0, 1'b0);
      prog.ld(ACT_CMD, 1'b0, CMD_NOP);
      rdm(CMD_RD_FLASH, 8'h41, 8'h34, 1'b0);
      rc(1'b1, 1'b0, 8'h12);
      prog.ld(ACT_ADDR, 1'b0, 8'h01);
      rc(1'b1, 1'b0, ERASED_BYTE);
   endtask
   task automatic t_lock();
      prog.ld(ACT_CMD, 1'b0, CMD_WR_LOCK);
      prog.ld(ACT_DATA, 1'b0, 8'hFC);
      wr(1'b0, 1'b0);
      prog.ld(ACT_DATA, 1'b0, 8'hC3);
      wr(1'b0, 1'b0);
      prog.ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
      prog.ld(ACT_DATA, 1'b0, 8'h00);
      wr(1'b0, 1'b0);
      prog.ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
      rc(1'b1, 1'b0, 8'hFC);
      rc(1'b0, 1'b0, 8'h55);
      prog.ld(ACT_CMD, 1'b0, CMD_ERASE);
      wr(1'b0, 1'b0);
      prog.ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
      rc(1'b1, 1'b0, LOCK_RST);
      rc(1'b0, 1'b0, 8'h55);
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      repeat (12) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      t_entry();
      t_sig();
      t_fuse();
      t_erase();
      t_ee();
      t_flash();
      t_lock();
      finish_test();
   end
endmodule // tb
`default_nettype wire
